// >>> design/msfc_pkg.sv
/*
 * package for the stop and speed pulse configuration word: offset, field
 * layout, reset value, code tables and timing constants.
 * assumes a single 200 MHz system clock and a 32-bit register bus.
 */
package msfc_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] MSFC_OFS_CFG2 = 8'h88;
   localparam logic [31:0] MSFC_CFG2_RESET = 32'h00000000;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int MSFC_PARITY_BIT = 31;
   localparam int MSFC_MODE_LSB = 29;
   localparam int MSFC_DIV_LSB = 25;
   localparam int MSFC_RSVD_HI_BIT = 24;
   localparam int MSFC_EMF_LSB = 21;
   localparam int MSFC_STOP_LSB = 18;
   localparam int MSFC_BRK_LSB = 14;
   localparam int MSFC_DUTY_LSB = 11;
   localparam int MSFC_PIN_DUTY_LSB = 8;
   localparam int MSFC_SURGE_BIT = 7;
   localparam int MSFC_ILIM_LSB = 3;

   // ****************************************************************
   // code values
   // ****************************************************************
   localparam logic [3:0] MSFC_DIV_ZERO_AS = 4'h3;
   localparam logic [2:0] MSFC_EMF_FIRST_RSVD = 3'h6;
   localparam logic [3:0] MSFC_ILIM_RSVD = 4'h0;
   localparam logic [9:0] MSFC_DUTY_FULL = 10'h3E8;
   // duty threshold in per mille by code, code 7 first; code 0 is full duty, so it engages at once
   localparam logic [7:0][9:0] MSFC_DUTY_PERMIL = {10'h019, 10'h032, 10'h04B, 10'h064, 10'h096, 10'h0FA,
      10'h1F4, MSFC_DUTY_FULL};
   // brake time in milliseconds by duration code, code 15 first
   localparam logic [15:0][13:0] MSFC_BRAKE_MS = {
      14'h3A98, 14'h2710, 14'h1388, 14'h09C4, 14'h03E8, 14'h01F4, 14'h00FA, 14'h0064,
      14'h004B, 14'h0032, 14'h0019, 14'h000F, 14'h000A, 14'h0005, 14'h0002, 14'h0001};

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int MSFC_CLK_MHZ = 200;
   localparam int MSFC_MS_CYCLES = MSFC_CLK_MHZ * 1000;

   typedef enum logic [1:0] {MODE_BOTH, MODE_CLOSED, MODE_FIRST_TRY, MODE_RSVD} msfc_mode_t;
   typedef enum logic [2:0] {STOP_HIZ, STOP_RECIRC, STOP_LOW_BRAKE, STOP_HIGH_BRAKE, STOP_SPIN_DOWN,
      STOP_RSVD5, STOP_RSVD6, STOP_RSVD7} msfc_stop_t;

   // configuration word split into its fields
   typedef struct packed {
      logic parity;
      msfc_mode_t mode;
      logic [3:0] divider;
      logic rsvd_hi;
      logic [2:0] emf_thr;
      msfc_stop_t stop;
      logic [3:0] brake_time;
      logic [2:0] duty_thr;
      logic [2:0] pin_duty_thr;
      logic surge_en;
      logic [3:0] ilimit;
      logic [2:0] rsvd_lo;
   } msfc_cfg_t;

   // decoded settings handed to the motor side
   typedef struct packed {
      logic pulse_en;
      logic surge_en;
      logic [3:0] ilimit_dv;
      logic [4:0] emf_mv;
      logic rsvd_code;
   } msfc_drive_t;

endpackage

// >>> design/msfc_top.sv
/*
 * configuration word two of the motor controller with its consumers:
 * speed pulse divider, stop method engagement and brake timer.
 * assumes an Avalon-MM master on CLK_SYS, same-clock motor logic inputs
 * and an asynchronous brake pin.
 */
// Chosen here: the Avalon-MM register port.
// Function
// - configuration word two sits at 0x88 and resets to all zeros.
// - two-bit speed pulse mode: both loops, closed only, open first try, reserved.
// - speed pulse divided by code 1..15; code 0 divides by three.
// - back-EMF threshold codes 0..5 give 1,2,5,10,20,30 mV; 6,7 reserved.
// - stop method: Hi-Z, recirculation, low brake, high brake, spin down; 5..7 reserved.
// - brake duration codes give 1 to 15000 ms during stop.
// - stop duty threshold: immediate or 50..2.5 percent for braking and spin down.
// - brake pin duty threshold uses the same table for low-side braking.
// - bit 7 enables anti-voltage-surge protection.
// - per-cycle current limit 0.1 V steps for codes 1..15; code 0 reserved.
`timescale 1ns/1ps
module msfc_top #(
   parameter int CYCLES_PER_MS = msfc_pkg::MSFC_MS_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic ZC_PULSE,
   input wire logic CLOSED_LOOP,
   input wire logic FIRST_TRY,
   input wire logic STOP_REQ,
   input wire logic BRAKE_PIN,
   input wire logic [9:0] DUTY_PERMIL,
   output logic SPEED_PULSE_OUT,
   output msfc_pkg::msfc_drive_t DRIVE,
   output msfc_pkg::msfc_stop_t STOP_DRIVE,
   output logic STOP_ENGAGED,
   output logic BRAKE_BUSY,
   output logic PIN_BRAKE_ENGAGED
);
   import msfc_pkg::*;

   // ****************************************************************
   // functions
   // ****************************************************************
   // duty threshold in per mille; code 0 means immediate (full duty)
   function automatic logic [9:0] duty_permil(input logic [2:0] code);
      duty_permil = MSFC_DUTY_PERMIL[code];
   endfunction

   // ****************************************************************
   // register bus
   // ****************************************************************
   logic [31:0] cfg;
   logic [31:0] next_cfg;
   logic ack;
   logic next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic req;
   logic hit;
   msfc_cfg_t f;

   assign req = AVS_READ | AVS_WRITE;
   assign hit = (AVS_ADDRESS == MSFC_OFS_CFG2);
   assign AVS_WAITREQUEST = req & ~ack;
   assign AVS_READDATA = rdata;
   assign f = msfc_cfg_t'(cfg);

   // one wait cycle, write lands on the accepting edge, bytes by lane
   always_comb
   begin
      next_ack = req & ~ack;
      next_cfg = cfg;
      next_rdata = rdata;
      if (req && !ack)
      begin
         next_rdata = hit ? cfg : 32'h00000000;
      end
      if (AVS_WRITE && ack && hit)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (AVS_BYTEENABLE[i])
            begin
               next_cfg[i*8 +: 8] = AVS_WRITEDATA[i*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cfg <= MSFC_CFG2_RESET;
         ack <= 1'b0;
         rdata <= 32'h00000000;
      end
      else
      begin
         cfg <= next_cfg;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // decoded settings
   // ****************************************************************
   logic pulse_en;
   logic [3:0] div_n;
   logic [4:0] emf_mv;

   // speed pulse gating by loop state
   always_comb
   begin
      case (f.mode)
         MODE_BOTH: pulse_en = 1'b1;
         MODE_CLOSED: pulse_en = CLOSED_LOOP;
         MODE_FIRST_TRY: pulse_en = CLOSED_LOOP | FIRST_TRY;
         default: pulse_en = 1'b0;
      endcase
      case (f.emf_thr)
         3'h0: emf_mv = 5'h01;
         3'h1: emf_mv = 5'h02;
         3'h2: emf_mv = 5'h05;
         3'h3: emf_mv = 5'h0A;
         3'h4: emf_mv = 5'h14;
         3'h5: emf_mv = 5'h1E;
         default: emf_mv = 5'h00;
      endcase
      div_n = (f.divider == 4'h0) ? MSFC_DIV_ZERO_AS : f.divider;
   end

   // registered drive word
   msfc_drive_t drive;
   msfc_drive_t next_drive;

   always_comb
   begin
      next_drive.pulse_en = pulse_en;
      next_drive.surge_en = f.surge_en;
      next_drive.ilimit_dv = f.ilimit;
      next_drive.emf_mv = emf_mv;
      next_drive.rsvd_code = (f.mode == MODE_RSVD) | (f.emf_thr >= MSFC_EMF_FIRST_RSVD)
         | (f.stop > STOP_SPIN_DOWN) | (f.ilimit == MSFC_ILIM_RSVD);
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
         drive <= '0;
      else
         drive <= next_drive;
   end
   assign DRIVE = drive;

   // ****************************************************************
   // speed pulse divider
   // ****************************************************************
   logic [3:0] pcnt;
   logic [3:0] next_pcnt;
   logic pout;
   logic next_pout;

   // toggle the output once every div_n input pulses
   always_comb
   begin
      next_pcnt = pcnt;
      next_pout = pout;
      if (!pulse_en)
      begin
         next_pcnt = 4'h0;
      end
      else if (ZC_PULSE)
      begin
         if (pcnt + 4'h1 >= div_n)
         begin
            next_pcnt = 4'h0;
            next_pout = ~pout;
         end
         else
            next_pcnt = pcnt + 4'h1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pcnt <= 4'h0;
         pout <= 1'b0;
      end
      else
      begin
         pcnt <= next_pcnt;
         pout <= next_pout;
      end
   end
   assign SPEED_PULSE_OUT = pout;

   // ****************************************************************
   // stop and brake control
   // ****************************************************************
   logic pin_s1;
   logic pin_s2;
   logic engage;
   logic pin_engage;
   logic [31:0] sub;
   logic [31:0] next_sub;
   logic [13:0] ms_left;
   logic [13:0] next_ms_left;
   logic busy;
   logic next_busy;
   logic stop_eng;
   logic next_stop_eng;
   logic pin_eng;

   // brake pin synchroniser
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end
      else
      begin
         pin_s1 <= BRAKE_PIN;
         pin_s2 <= pin_s1;
      end
   end

   // braking and spin down wait for the duty threshold
   always_comb
   begin
      case (f.stop)
         STOP_HIZ, STOP_RECIRC: engage = STOP_REQ;
         STOP_LOW_BRAKE, STOP_HIGH_BRAKE, STOP_SPIN_DOWN:
            engage = STOP_REQ & (DUTY_PERMIL <= duty_permil(f.duty_thr));
         default: engage = 1'b0;
      endcase
      pin_engage = pin_s2 & (DUTY_PERMIL <= duty_permil(f.pin_duty_thr));
   end

   // brake timer runs the selected duration after engagement
   always_comb
   begin
      next_stop_eng = engage;
      next_busy = busy;
      next_sub = sub;
      next_ms_left = ms_left;
      if (engage && !stop_eng)
      begin
         next_busy = 1'b1;
         next_sub = 32'(CYCLES_PER_MS - 1);
         next_ms_left = MSFC_BRAKE_MS[f.brake_time];
      end
      else if (busy)
      begin
         if (sub != 32'h00000000)
            next_sub = sub - 32'h00000001;
         else if (ms_left == 14'h0001)
            next_busy = 1'b0;
         else
         begin
            next_sub = 32'(CYCLES_PER_MS - 1);
            next_ms_left = ms_left - 14'h0001;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         stop_eng <= 1'b0;
         busy <= 1'b0;
         sub <= 32'h00000000;
         ms_left <= 14'h0000;
         pin_eng <= 1'b0;
      end
      else
      begin
         stop_eng <= next_stop_eng;
         busy <= next_busy;
         sub <= next_sub;
         ms_left <= next_ms_left;
         pin_eng <= pin_engage;
      end
   end

   assign STOP_ENGAGED = stop_eng;
   assign STOP_DRIVE = f.stop;
   assign BRAKE_BUSY = busy;
   assign PIN_BRAKE_ENGAGED = pin_eng;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   bus_wait_a: assert property ((req && !ack) |=> !AVS_WAITREQUEST || !req)
      else $error("request not answered after one wait cycle");
   word_store_a: assert property ((AVS_WRITE && ack && hit && AVS_BYTEENABLE == 4'hF)
      |=> cfg == $past(AVS_WRITEDATA))
      else $error("full write not stored");
   miss_read_a: assert property ((AVS_READ && !ack && !hit) |=> AVS_READDATA == 32'h00000000)
      else $error("unmapped read not zero");
   closed_gate_a: assert property ((f.mode == MODE_CLOSED && !CLOSED_LOOP) |=> !drive.pulse_en)
      else $error("pulse enabled outside closed loop");
   div_zero_a: assert property ((f.divider == 4'h0 && pulse_en && ZC_PULSE && pcnt == 4'h2) |=> pcnt == 4'h0)
      else $error("code zero does not divide by three");
   emf_code_a: assert property ((f.emf_thr == 3'h5) |=> drive.emf_mv == 5'h1E)
      else $error("emf threshold wrong");
   hiz_now_a: assert property ((f.stop == STOP_HIZ && STOP_REQ) |=> STOP_ENGAGED)
      else $error("hi-z stop not immediate");
   brake_short_a: assert property ((engage && !stop_eng && f.brake_time == 4'h0)
      |=> busy ##1 busy [*1] ##0 (ms_left == 14'h0001))
      else $error("brake timer load wrong");
   duty_block_a: assert property ((f.stop == STOP_SPIN_DOWN && f.duty_thr == 3'h1 && DUTY_PERMIL > 10'h1F4)
      |=> !STOP_ENGAGED)
      else $error("spin down engaged above threshold");
   pin_imm_a: assert property ((pin_s2 && f.pin_duty_thr == 3'h0) |=> PIN_BRAKE_ENGAGED)
      else $error("pin brake not immediate");
   surge_bit_a: assert property ($rose(cfg[MSFC_SURGE_BIT]) |=> DRIVE.surge_en)
      else $error("surge enable not applied");

endmodule // msfc_top

// >>> bench/msfc_motor_model.sv
/*
 * motor stand-in: back-emf zero-crossing pulses that feed the speed pulse divider.
 * assumes the bench clock and reset; the registered pulse train follows spin one cycle late, first pulse GAP cycles after spin rises.
 */
`timescale 1ns/1ps
module msfc_motor_model #(
   parameter int GAP = 3
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic spin,
   output logic zc_pulse
);
   logic [7:0] cnt;

   // ****************************************************************
   // one-cycle crossing pulse every GAP cycles while spinning
   // ****************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt <= 8'h00;
         zc_pulse <= 1'b0;
      end
      else
      begin
         cnt <= (spin && cnt < 8'(GAP - 1)) ? cnt + 8'h01 : 8'h00;
         zc_pulse <= spin && cnt == 8'(GAP - 1);
      end
   end
endmodule // msfc_motor_model

// >>> bench/motor_stop_fg_config_bench.sv
/*
 * self-checking bench: register access, speed pulse, decoded settings, stop and brake.
 * assumes msfc_pkg and msfc_top compiled first; one millisecond is scaled to MS cycles.
 */
`timescale 1ns/1ps
module motor_stop_fg_config_bench;
   import msfc_pkg::*;
   localparam int MS = 4;
   logic CLK_SYS = 1'b0, ARST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, spin = 1'b0;
   logic CLOSED_LOOP = 1'b0, FIRST_TRY = 1'b0, STOP_REQ = 1'b0, BRAKE_PIN = 1'b0;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic [31:0] AVS_WRITEDATA = 32'h00000000;
   logic [3:0] AVS_BYTEENABLE = 4'hF;
   logic [9:0] DUTY_PERMIL = 10'h000;
   logic [31:0] AVS_READDATA, rd;
   logic AVS_WAITREQUEST, ZC_PULSE, SPEED_PULSE_OUT, STOP_ENGAGED, BRAKE_BUSY, PIN_BRAKE_ENGAGED, b;
   msfc_drive_t DRIVE;
   msfc_stop_t STOP_DRIVE;
   msfc_cfg_t c;
   int fail_count = 0, cmp_count = 0, n;
   int dcode[5] = '{0, 1, 2, 7, 15};
   int dexp[5] = '{3, 1, 2, 7, 15};
   int emf[8] = '{1, 2, 5, 10, 20, 30, 0, 0};
   int thr[8] = '{1000, 500, 250, 150, 100, 75, 50, 25};
   int brk[3] = '{1, 2, 5};

   msfc_top #(.CYCLES_PER_MS(MS)) msfc_top_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .ZC_PULSE(ZC_PULSE), .CLOSED_LOOP(CLOSED_LOOP), .FIRST_TRY(FIRST_TRY), .STOP_REQ(STOP_REQ),
      .BRAKE_PIN(BRAKE_PIN), .DUTY_PERMIL(DUTY_PERMIL), .SPEED_PULSE_OUT(SPEED_PULSE_OUT), .DRIVE(DRIVE),
      .STOP_DRIVE(STOP_DRIVE), .STOP_ENGAGED(STOP_ENGAGED), .BRAKE_BUSY(BRAKE_BUSY),
      .PIN_BRAKE_ENGAGED(PIN_BRAKE_ENGAGED));
   msfc_motor_model #(.GAP(3)) msfc_motor_model_i (.clk(CLK_SYS), .arst_n(ARST_N), .spin(spin),
      .zc_pulse(ZC_PULSE));

   // ****************************************************************
   // clock, watchdog and shared tasks
   // ****************************************************************
   always #2.5 CLK_SYS = ~CLK_SYS;
   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      fail_count++;
      report_and_stop();
   end
   task automatic report_and_stop();
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge CLK_SYS);
      #1;
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge CLK_SYS);
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      @(posedge CLK_SYS iff !AVS_WAITREQUEST);
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic put(input msfc_cfg_t v);
      bus(1'b1, MSFC_OFS_CFG2, v, 4'hF);
      tick(3);
   endtask

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge CLK_SYS);
      ARST_N <= 1'b1;
      bus(1'b0, MSFC_OFS_CFG2, 32'h0, 4'hF);
      chk("cfg reset", rd, 32'h00000000);
      chk("rsvd after reset", DRIVE.rsvd_code, 1);
      bus(1'b1, MSFC_OFS_CFG2, 32'hFFFFFFFF, 4'hF);
      bus(1'b1, MSFC_OFS_CFG2, 32'h00000000, 4'h2);
      bus(1'b1, 8'h8A, 32'h00000000, 4'hF);
      bus(1'b0, MSFC_OFS_CFG2, 32'h0, 4'hF);
      chk("cfg readback", rd, 32'hFFFF00FF);
      bus(1'b0, 8'h8C, 32'h0, 4'hF);
      chk("unmapped read", rd, 32'h00000000);
      // decoded threshold, surge enable and current limit
      for (int i = 0; i < 8; i++)
      begin
         c = '0;
         c.emf_thr = i[2:0];
         c.ilimit = 4'(2 * i + 1);
         c.surge_en = i[0];
         put(c);
         chk("emf mv", DRIVE.emf_mv, emf[i]);
         chk("ilimit", DRIVE.ilimit_dv, 2 * i + 1);
         chk("surge", DRIVE.surge_en, i[0]);
         chk("rsvd emf", DRIVE.rsvd_code, i >= 6);
      end
      // pulse enable for every mode and loop state
      for (int m = 0; m < 4; m++)
         for (int k = 0; k < 3; k++)
         begin
            c = '0;
            c.mode = msfc_mode_t'(m[1:0]);
            c.ilimit = 4'h1;
            @(posedge CLK_SYS);
            CLOSED_LOOP <= (k == 2);
            FIRST_TRY <= (k == 1);
            put(c);
            chk("pulse en", DRIVE.pulse_en, m == 0 || (m == 1 && k == 2) || (m == 2 && k > 0));
            chk("rsvd mode", DRIVE.rsvd_code, m == 3);
         end
      // divider: pulses while disabled clear the count, then count up to the toggle
      for (int i = 0; i < 5; i++)
      begin
         c = '0;
         c.mode = MODE_CLOSED;
         c.divider = dcode[i][3:0];
         c.ilimit = 4'h1;
         @(posedge CLK_SYS);
         CLOSED_LOOP <= 1'b0;
         spin <= 1'b1;
         put(c);
         tick(8);
         // stop the train before enabling, so a last crossing cannot slip into the count
         @(posedge CLK_SYS);
         spin <= 1'b0;
         tick(4);
         b = SPEED_PULSE_OUT;
         n = 0;
         @(posedge CLK_SYS);
         spin <= 1'b1;
         CLOSED_LOOP <= 1'b1;
         repeat (100)
         begin
            @(posedge CLK_SYS);
            if (ZC_PULSE)
               n++;
            #1;
            if (SPEED_PULSE_OUT !== b)
               break;
         end
         chk("divide", n, dexp[i]);
         @(posedge CLK_SYS);
         spin <= 1'b0;
      end
      // every stop method at a duty above the 50 percent threshold
      @(posedge CLK_SYS);
      DUTY_PERMIL <= 10'd600;
      STOP_REQ <= 1'b1;
      for (int s = 0; s < 8; s++)
      begin
         c = '0;
         c.stop = msfc_stop_t'(s[2:0]);
         c.duty_thr = 3'h1;
         c.ilimit = 4'h1;
         put(c);
         chk("stop drive", STOP_DRIVE, s);
         chk("rsvd stop", DRIVE.rsvd_code, s >= 5);
         chk("stop engaged", STOP_ENGAGED, s < 2);
      end
      // duty thresholds for stop and pin braking, one above and at each limit; code 0 only at full duty
      @(posedge CLK_SYS);
      BRAKE_PIN <= 1'b1;
      for (int t = 0; t < 8; t++)
         for (int j = 0; j < 2; j++)
         begin
            c = '0;
            c.stop = msfc_stop_t'(3'(2 + t % 3));
            c.duty_thr = t[2:0];
            c.pin_duty_thr = t[2:0];
            @(posedge CLK_SYS);
            DUTY_PERMIL <= 10'((t == 0) ? 1000 : thr[t] + 1 - j);
            put(c);
            tick(3);
            chk("duty engage", STOP_ENGAGED, j == 1 || t == 0);
            chk("pin engage", PIN_BRAKE_ENGAGED, j == 1 || t == 0);
         end
      // brake duration counted from the rise of the stop request
      for (int i = 0; i < 3; i++)
      begin
         c = '0;
         c.brake_time = i[3:0];
         @(posedge CLK_SYS);
         STOP_REQ <= 1'b0;
         put(c);
         tick(100);
         @(posedge CLK_SYS);
         STOP_REQ <= 1'b1;
         n = 0;
         repeat (120)
         begin
            @(posedge CLK_SYS);
            #1;
            if (BRAKE_BUSY === 1'b1)
               n++;
         end
         chk("brake cycles", n, brk[i] * MS);
      end
      report_and_stop();
   end
endmodule // motor_stop_fg_config_bench
